// File: logic/mdsm_top.sv
module mdsm_top #(
  parameter int SEL_W = mdsm_pkg::SEL_W
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [2**SEL_W-1:0] modulator_periph,
  input  wire logic [2**SEL_W-1:0] carrier_periph,
  input  wire logic              external_modulator_pin,
  input  wire logic              external_carrier_pin_one,
  input  wire logic              external_carrier_pin_two,
  input  wire logic              reference_clock_output,
  input  wire logic              internal_fast_oscillator,
  output logic                   modulated_output
);

  // --------------------------------------------------------------------
  // State.
  // --------------------------------------------------------------------
  typedef struct packed {
    logic                 enable;
    logic                 out_inv;
    logic                 soft_bit;
    logic [SEL_W-1:0]     data_sel;
    logic                 hi_inv;
    logic                 hi_sync;
    logic [SEL_W-1:0]     hi_sel;
    logic                 lo_inv;
    logic                 lo_sync;
    logic [SEL_W-1:0]     lo_sel;
    logic                 hi_act;
    logic                 lo_act;
    logic                 pin;
    logic                 status;
    mdsm_pkg::mdsm_apb_e  apb;
    logic [31:0]          rdata;
    logic                 ready;
    logic                 slverr;
  } mdsm_state_s;

  mdsm_state_s state_reg;
  mdsm_state_s state_next;

  logic             data_raw;
  logic             hi_raw;
  logic             lo_raw;
  logic             data_lvl;
  logic             hi_lvl;
  logic             hi_fall;
  logic             lo_lvl;
  logic             lo_fall;
  logic [31:0]      read_word;
  logic             addr_hit;

  // --------------------------------------------------------------------
  // Source selection.
  // --------------------------------------------------------------------
  function automatic logic pick_carrier(input logic [SEL_W-1:0] sel,
                                        input logic [2**SEL_W-1:0] periph,
                                        input logic pin_one,
                                        input logic pin_two,
                                        input logic ref_clk,
                                        input logic fast_osc);
    logic v;
    v = periph[sel];
    case (sel)
      mdsm_pkg::CAR_GROUND:    v = 1'b0;
      mdsm_pkg::CAR_PIN_ONE:   v = pin_one;
      mdsm_pkg::CAR_PIN_TWO:   v = pin_two;
      mdsm_pkg::CAR_REF_CLOCK: v = ref_clk;
      mdsm_pkg::CAR_RESERVED:  v = 1'b0;
      mdsm_pkg::CAR_FAST_OSC:  v = fast_osc;
      default:                 v = periph[sel];
    endcase
    return v;
  endfunction : pick_carrier

  always_comb begin
    data_raw = modulator_periph[state_reg.data_sel];
    hi_raw   = 1'b0;
    lo_raw   = 1'b0;
    if (state_reg.enable) begin
      if (state_reg.data_sel == mdsm_pkg::DATA_SOFT_BIT) begin
        data_raw = state_reg.soft_bit;
      end else if (state_reg.data_sel == mdsm_pkg::DATA_EXT_PIN) begin
        data_raw = external_modulator_pin;
      end
      hi_raw = pick_carrier(state_reg.hi_sel, carrier_periph, external_carrier_pin_one,
                            external_carrier_pin_two, reference_clock_output,
                            internal_fast_oscillator) ^ state_reg.hi_inv;
      lo_raw = pick_carrier(state_reg.lo_sel, carrier_periph, external_carrier_pin_one,
                            external_carrier_pin_two, reference_clock_output,
                            internal_fast_oscillator) ^ state_reg.lo_inv;
    end else begin
      data_raw = state_reg.soft_bit;
    end
  end

  // --------------------------------------------------------------------
  // Synchronisers for the three mixed signals.
  // --------------------------------------------------------------------
  mdsm_edge_sync #(
    .STAGES   (mdsm_pkg::SYNC_STAGES)
  ) u_sync_data (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (data_raw),
    .level    (data_lvl),
    .fall     ()
  );

  mdsm_edge_sync #(
    .STAGES   (mdsm_pkg::SYNC_STAGES)
  ) u_sync_high (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (hi_raw),
    .level    (hi_lvl),
    .fall     (hi_fall)
  );

  mdsm_edge_sync #(
    .STAGES   (mdsm_pkg::SYNC_STAGES)
  ) u_sync_low (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (lo_raw),
    .level    (lo_lvl),
    .fall     (lo_fall)
  );

  // --------------------------------------------------------------------
  // Register read view.
  // --------------------------------------------------------------------
  always_comb begin
    read_word = mdsm_pkg::RESET_WORD;
    addr_hit  = 1'b1;
    case (paddr)
      mdsm_pkg::OFS_CONTROL: begin
        read_word[mdsm_pkg::CTL_ENABLE]   = state_reg.enable;
        read_word[mdsm_pkg::CTL_OUT_INV]  = state_reg.out_inv;
        read_word[mdsm_pkg::CTL_STATUS]   = state_reg.status;
        read_word[mdsm_pkg::CTL_SOFT_BIT] = state_reg.soft_bit;
      end
      mdsm_pkg::OFS_SOURCE: begin
        read_word[SEL_W-1:0] = state_reg.data_sel;
      end
      mdsm_pkg::OFS_HIGH_CAR: begin
        read_word[mdsm_pkg::CAR_INVERT] = state_reg.hi_inv;
        read_word[mdsm_pkg::CAR_SYNC]   = state_reg.hi_sync;
        read_word[SEL_W-1:0]            = state_reg.hi_sel;
      end
      mdsm_pkg::OFS_LOW_CAR: begin
        read_word[mdsm_pkg::CAR_INVERT] = state_reg.lo_inv;
        read_word[mdsm_pkg::CAR_SYNC]   = state_reg.lo_sync;
        read_word[SEL_W-1:0]            = state_reg.lo_sel;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // Next state: bus slave and mixer.
  // --------------------------------------------------------------------
  always_comb begin
    state_next        = state_reg;
    state_next.ready  = 1'b0;
    state_next.slverr = 1'b0;

    // The answer comes one cycle into the access phase.
    case (state_reg.apb)
      mdsm_pkg::MDSM_APB_IDLE: begin
        if (psel && penable) begin
          state_next.apb    = mdsm_pkg::MDSM_APB_DONE;
          state_next.ready  = 1'b1;
          state_next.slverr = ~addr_hit;
          state_next.rdata  = (!pwrite && addr_hit) ? read_word : mdsm_pkg::RESET_WORD;
          if (pwrite) begin
            case (paddr)
              mdsm_pkg::OFS_CONTROL: begin
                state_next.enable   = pwdata[mdsm_pkg::CTL_ENABLE];
                state_next.out_inv  = pwdata[mdsm_pkg::CTL_OUT_INV];
                state_next.soft_bit = pwdata[mdsm_pkg::CTL_SOFT_BIT];
              end
              mdsm_pkg::OFS_SOURCE: begin
                state_next.data_sel = pwdata[SEL_W-1:0];
              end
              mdsm_pkg::OFS_HIGH_CAR: begin
                state_next.hi_inv  = pwdata[mdsm_pkg::CAR_INVERT];
                state_next.hi_sync = pwdata[mdsm_pkg::CAR_SYNC];
                state_next.hi_sel  = pwdata[SEL_W-1:0];
              end
              mdsm_pkg::OFS_LOW_CAR: begin
                state_next.lo_inv  = pwdata[mdsm_pkg::CAR_INVERT];
                state_next.lo_sync = pwdata[mdsm_pkg::CAR_SYNC];
                state_next.lo_sel  = pwdata[SEL_W-1:0];
              end
              default: begin
                state_next.rdata = mdsm_pkg::RESET_WORD;
              end
            endcase
          end
        end
      end
      mdsm_pkg::MDSM_APB_DONE: begin
        state_next.apb = mdsm_pkg::MDSM_APB_IDLE;
      end
      default: begin
        state_next.apb = mdsm_pkg::MDSM_APB_IDLE;
      end
    endcase

    // Carrier activation follows the modulator; a synced carrier only
    // switches on its own falling edge, so no pulse is cut short.
    if (data_lvl) begin
      if (!state_reg.hi_sync || hi_fall) begin
        state_next.hi_act = 1'b1;
      end
      if (!state_reg.hi_sync || !state_reg.hi_act || state_reg.lo_sync) begin
        if (!state_reg.lo_sync || lo_fall) begin
          state_next.lo_act = 1'b0;
        end
      end else begin
        state_next.lo_act = 1'b0;
      end
    end else begin
      if (!state_reg.lo_sync || lo_fall) begin
        state_next.lo_act = 1'b1;
      end
      if (state_reg.hi_sync) begin
        if (hi_fall) begin
          state_next.hi_act = 1'b0;
        end
      end else begin
        state_next.hi_act = 1'b0;
      end
    end
    if (data_lvl && !state_reg.hi_sync) begin
      state_next.lo_act = state_reg.lo_sync ? (state_reg.lo_act & ~lo_fall) : 1'b0;
    end
    if (!data_lvl && state_reg.hi_sync && state_reg.lo_sync) begin
      state_next.lo_act = state_reg.lo_act | lo_fall;
    end

    state_next.status = (state_reg.hi_act & hi_lvl) | (state_reg.lo_act & lo_lvl);
    if (state_reg.enable) begin
      state_next.pin = state_next.status ^ state_reg.out_inv;
    end else begin
      state_next.pin = 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // State register.
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg        <= '0;
      state_reg.apb    <= mdsm_pkg::MDSM_APB_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata           = state_reg.rdata;
  assign pready           = state_reg.ready;
  assign pslverr          = state_reg.slverr;
  assign modulated_output = state_reg.pin;

endmodule : mdsm_top

// File: logic/mdsm_pkg.sv
package mdsm_pkg;

  localparam int          SEL_W          = 4;
  localparam int          SYNC_STAGES    = 2;

  localparam logic [7:0]  OFS_CONTROL    = 8'h00;
  localparam logic [7:0]  OFS_SOURCE     = 8'h04;
  localparam logic [7:0]  OFS_HIGH_CAR   = 8'h08;
  localparam logic [7:0]  OFS_LOW_CAR    = 8'h0C;

  localparam int          CTL_ENABLE     = 7;
  localparam int          CTL_OUT_INV    = 4;
  localparam int          CTL_STATUS     = 3;
  localparam int          CTL_SOFT_BIT   = 0;
  localparam int          CAR_INVERT     = 6;
  localparam int          CAR_SYNC       = 5;

  localparam logic [3:0]  DATA_SOFT_BIT  = 4'h0;
  localparam logic [3:0]  DATA_EXT_PIN   = 4'h1;
  localparam logic [3:0]  CAR_GROUND     = 4'h0;
  localparam logic [3:0]  CAR_PIN_ONE    = 4'h1;
  localparam logic [3:0]  CAR_PIN_TWO    = 4'h2;
  localparam logic [3:0]  CAR_REF_CLOCK  = 4'h3;
  localparam logic [3:0]  CAR_RESERVED   = 4'h9;
  localparam logic [3:0]  CAR_FAST_OSC   = 4'hB;

  localparam logic [31:0] RESET_WORD     = 32'h0000_0000;

  typedef enum logic [1:0] {
    MDSM_APB_IDLE = 2'b01,
    MDSM_APB_DONE = 2'b10
  } mdsm_apb_e;

endpackage : mdsm_pkg

// File: logic/mdsm_edge_sync.sv
module mdsm_edge_sync #(
  parameter int STAGES = 2
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic async_in,
  output logic      level,
  output logic      fall
);

  // --------------------------------------------------------------------
  // Synchroniser chain with a falling-edge detector on its last stage.
  // --------------------------------------------------------------------
  logic [STAGES-1:0] chain_reg;
  logic              prev_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chain_reg <= '0;
      prev_reg  <= 1'b0;
    end else begin
      chain_reg <= {chain_reg[STAGES-2:0], async_in};
      prev_reg  <= chain_reg[STAGES-1];
    end
  end

  assign level = chain_reg[STAGES-1];
  assign fall  = prev_reg & ~chain_reg[STAGES-1];

endmodule : mdsm_edge_sync

// File: test/mdsm_monitor.sv
module mdsm_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        modulated_output
);
  // ----
  // Enable shadow and checks.
  // ----
  logic en_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg <= 1'b0;
    end else if (psel && penable && pready && pwrite && paddr == 8'h00) begin
      en_reg <= pwdata[7];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence off_s;
    (!en_reg) [*6];
  endsequence
  sequence ctl_rd_s;
    pready && !pwrite && paddr == 8'h00;
  endsequence
  chk_off_low: assert property (off_s |-> !modulated_output)
    else $error("pin not low while disabled");
  chk_off_status: assert property (off_s ##0 ctl_rd_s |-> !prdata[3])
    else $error("status set while disabled");
  chk_reset_idle: assert property ($rose(presetn) |-> !pready && !modulated_output)
    else $error("outputs active after reset");
  chk_ready_next: assert property (psel && penable && !pready |=> pready)
    else $error("no ready after access");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_setup_idle: assert property (psel && !penable |-> !pready ##1 !pready)
    else $error("ready during setup");
  chk_err_map: assert property (pready |->
    pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C}))
    else $error("error flag wrong for address");
  chk_err_zero: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("data on refused access");
  chk_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
endmodule : mdsm_monitor

// File: test/mdsm_sources.sv
module mdsm_sources (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        run,
  input wire logic [39:0] level,
  output logic     [39:0] src
);
  // ----
  // Source outputs, static or free running.
  // ----
  logic [5:0] cnt_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 6'h00;
    end else begin
      cnt_reg <= cnt_reg + 6'h01;
    end
  end
  // Running sources toggle at four rates so neighbouring codes differ.
  assign src = run ? {10{cnt_reg[5:2]}} : level;
endmodule : mdsm_sources

// File: test/test_data_signal_modulator.sv
module test_data_signal_modulator;
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Design, sources and scenarios.
  // ----
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, run, e, modulated_output;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [39:0] level, src;
  int          failures, n_tests;
  mdsm_sources mdsm_sources_i (.pclk, .presetn, .run, .level, .src);
  mdsm_top mdsm_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .modulator_periph(src[15:0]), .carrier_periph(src[31:16]),
    .external_modulator_pin(src[32]), .external_carrier_pin_one(src[33]),
    .external_carrier_pin_two(src[34]), .reference_clock_output(src[35]),
    .internal_fast_oscillator(src[36]), .modulated_output);
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  function automatic logic [31:0] ctl(input logic en, input logic oi, input logic mb);
    return {24'h0, en, 2'h0, oi, 3'h0, mb};
  endfunction : ctl
  task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    {q, e} = {prdata, pslverr};
    if (pready !== 1'b1) begin
      failures++;
      complete_run();
    end
    {psel, penable} <= 2'h0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic wait_out(input logic exp, input string name);
    repeat (10) @(posedge pclk);
    check(name, modulated_output, exp);
  endtask : wait_out
  task automatic edge_on(input int b);
    level[b] <= 1'b0;
    repeat (8) @(posedge pclk);
    level[b] <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask : edge_on
  task automatic t_reset;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      check("reset read", {e, q}, {i == 4, 32'h0});
    end
  endtask : t_reset
  task automatic t_mix;
    logic m, h, l, v, oi, x;
    for (int i = 0; i < 32; i++) begin
      {oi, v, l, h, m} = 5'(i);
      level[34:33] <= {l, h};
      wr(8'h08, {25'h0, v, 6'h01});
      wr(8'h0C, {25'h0, v, 6'h02});
      wr(8'h00, ctl(1'b1, oi, m));
      x = m ? h ^ v : l ^ v;
      wait_out(x ^ oi, "mixed pin");
      apb(1'b0, 8'h00, 32'h0);
      check("control", q, ctl(1'b1, oi, m) | {x, 3'h0});
    end
  endtask : t_mix
  task automatic t_off;
    level[33] <= 1'b0;
    wr(8'h08, 32'h01);
    wr(8'h00, ctl(1'b1, 1'b1, 1'b1));
    wait_out(1'b1, "inverted idle");
    wr(8'h00, ctl(1'b0, 1'b1, 1'b1));
    wait_out(1'b0, "disabled pin");
    apb(1'b0, 8'h00, 32'h0);
    check("disabled control", q, ctl(1'b0, 1'b1, 1'b1));
    apb(1'b0, 8'h08, 32'h0);
    check("kept select", q, 32'h01);
    wr(8'h00, ctl(1'b1, 1'b1, 1'b1));
    wait_out(1'b1, "enabled again");
  endtask : t_off
  task automatic t_codes;
    logic [3:0]  c;
    logic        x;
    logic [15:0] cq = 16'h5AA5;
    logic [15:0] mq = 16'hA55A;
    level <= 40'h2A_5AA5_A55A;
    wr(8'h08, 32'h01);
    wr(8'h0C, 32'h00);
    wr(8'h00, ctl(1'b1, 1'b0, 1'b0));
    for (int i = 1; i < 16; i++) begin
      c = 4'(i);
      wr(8'h04, 32'(c));
      wait_out(c == 4'h1 ? 1'b0 : mq[c], "modulator code");
    end
    wr(8'h04, 32'h0);
    for (int i = 0; i < 16; i++) begin
      c = 4'(i);
      wr(8'h08, 32'(c));
      wr(8'h0C, 32'(c));
      wr(8'h00, ctl(1'b1, 1'b0, c[0]));
      case (c)
        4'h0, 4'h2, 4'h9, 4'hB: x = 1'b0;
        4'h1, 4'h3: x = 1'b1;
        default: x = cq[c];
      endcase
      wait_out(x, "carrier code");
    end
  endtask : t_codes
  task automatic t_sync;
    level[34:33] <= 2'h1;
    wr(8'h08, 32'h21);
    wr(8'h0C, 32'h02);
    wr(8'h00, ctl(1'b1, 1'b0, 1'b1));
    edge_on(33);
    wr(8'h00, ctl(1'b1, 1'b0, 1'b0));
    wait_out(1'b1, "high held");
    edge_on(33);
    wait_out(1'b0, "low taken");
    level[34] <= 1'b1;
    wr(8'h08, 32'h01);
    wr(8'h0C, 32'h22);
    wr(8'h00, ctl(1'b1, 1'b0, 1'b1));
    edge_on(34);
    wr(8'h00, ctl(1'b1, 1'b0, 1'b0));
    wait_out(1'b0, "low waits");
    edge_on(34);
    wait_out(1'b1, "low active");
    wr(8'h08, 32'h21);
    wr(8'h00, ctl(1'b1, 1'b0, 1'b1));
    wait_out(1'b1, "low kept");
    edge_on(34);
    wait_out(1'b0, "both wait");
    edge_on(33);
    wait_out(1'b1, "high taken");
  endtask : t_sync
  task automatic t_run;
    int n;
    logic p;
    wr(8'h08, 32'h04);
    wr(8'h00, ctl(1'b1, 1'b0, 1'b1));
    run <= 1'b1;
    n = 0;
    p = modulated_output;
    repeat (64) begin
      @(posedge pclk);
      n += int'(modulated_output !== p);
      p = modulated_output;
    end
    run <= 1'b0;
    check("running carrier", n > 8, 1'b1);
  endtask : t_run
  initial begin
    {presetn, psel, penable, pwrite, run} = 5'h0;
    {paddr, pwdata, level} = 80'h0;
    {failures, n_tests} = 64'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_mix();
    t_off();
    t_codes();
    t_sync();
    t_run();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    complete_run();
  end
endmodule : test_data_signal_modulator

bind mdsm_top mdsm_monitor mdsm_monitor_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .modulated_output);
